// *** core/tsf_pkg.sv ***
// Shared constants and carrier types for the filter and status register bank
package tsf_pkg;
  // Register command codes
  localparam logic [7:0] TSF_CMD_COMMON_STATUS = 8'h02;
  localparam logic [7:0] TSF_CMD_CONFIG = 8'h03;
  localparam logic [7:0] TSF_CMD_CHAN_ENABLE = 8'h05;
  localparam logic [7:0] TSF_CMD_FILTER = 8'h06;
  localparam logic [7:0] TSF_CMD_DIODE_FAULT = 8'h07;
  localparam logic [7:0] TSF_CMD_THRESH1 = 8'h08;
  localparam logic [7:0] TSF_CMD_THRESH2 = 8'h09;
  localparam logic [7:0] TSF_CMD_THRESH3 = 8'h0A;
  localparam logic [7:0] TSF_CMD_ONE_SHOT = 8'h0F;

  // Reset values
  localparam logic [7:0] TSF_FILTER_RST = 8'h0F;
  localparam logic [7:0] TSF_CONFIG_RST = 8'h00;
  localparam logic [7:0] TSF_CHAN_EN_RST = 8'h1F;

  // Field positions
  localparam int TSF_REMOTE2_FILT_LSB = 2;
  localparam int TSF_REMOTE1_FILT_LSB = 0;
  localparam int TSF_STANDBY_BIT = 6;
  localparam int TSF_BUSY_BIT = 7;
  localparam int TSF_NOT_READY_BIT = 6;
  localparam int TSF_R2_OPEN_BIT = 3;
  localparam int TSF_R2_SHORT_BIT = 2;
  localparam int TSF_R1_OPEN_BIT = 1;
  localparam int TSF_R1_SHORT_BIT = 0;
  localparam logic [7:0] TSF_FILTER_MASK = 8'h0F;
  localparam logic [7:0] TSF_CONFIG_MASK = 8'h40;
  localparam logic [7:0] TSF_CHAN_EN_MASK = 8'h07;
  localparam logic [7:0] TSF_THRESH_MASK = 8'h07;

  // Filter encodings
  localparam logic [1:0] TSF_FILT_OFF = 2'h0;
  localparam logic [1:0] TSF_FILT_BASIC = 2'h1;
  localparam logic [1:0] TSF_FILT_RSVD = 2'h2;
  localparam logic [1:0] TSF_FILT_ENH = 2'h3;

  // Fault readout values
  localparam logic [10:0] TSF_UNSIGNED_FAULT = 11'h000;
  localparam logic [10:0] TSF_SIGNED_FAULT = 11'h400;

  // Power-up initialisation time
  localparam int TSF_INIT_MS = 30;
  localparam int TSF_CLK_MHZ = 100;
  localparam int TSF_INIT_CYCLES = TSF_INIT_MS * 1000 * TSF_CLK_MHZ;

  typedef enum logic [1:0] {
    TSF_FILTER_NONE,
    TSF_FILTER_BASIC,
    TSF_FILTER_ENHANCED
  } tsf_filter_mode_t;

  // Diode input condition seen by the analog comparators
  typedef struct packed {
    logic dplus_low;
    logic dplus_high;
  } tsf_diode_sense_t;

  typedef struct packed {
    logic open_fault;
    logic short_fault;
  } tsf_fault_t;

  // Register access strobe with its data
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } tsf_reg_req_t;
endpackage

// *** core/tsf_fault_class.sv ***
// Diode fault classifier with synchronised comparator levels
`timescale 1ns/1ns
module tsf_fault_class
  import tsf_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Comparator levels from the analog front end
  input tsf_diode_sense_t sense,
  // Classified fault
  output tsf_fault_t fault
);
  logic [2:0] low_sync_r, low_sync_nxt;
  logic [2:0] high_sync_r, high_sync_nxt;
  tsf_fault_t fault_r, fault_nxt;

  always_comb begin
    low_sync_nxt = {low_sync_r[1:0], sense.dplus_low};
    high_sync_nxt = {high_sync_r[1:0], sense.dplus_high};
    fault_nxt = fault_r;
    // Only levels agreed by two samples count, so a one-cycle comparator glitch cannot toggle it
    if (low_sync_r[2] == low_sync_r[1]) begin
      fault_nxt.short_fault = low_sync_r[2];
    end
    if (high_sync_r[2] == high_sync_r[1]) begin
      fault_nxt.open_fault = high_sync_r[2];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_sync_r <= 3'h0;
      high_sync_r <= 3'h0;
      fault_r <= '0;
    end else begin
      low_sync_r <= low_sync_nxt;
      high_sync_r <= high_sync_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign fault = fault_r;
endmodule

// *** core/tsf_init_timer.sv ***
// Power-up not-ready timer
`timescale 1ns/1ns
module tsf_init_timer
  import tsf_pkg::*;
#(
  parameter int INIT_CYCLES = TSF_INIT_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Status
  output logic not_ready
);
  logic [31:0] count_r, count_nxt;
  logic not_ready_r, not_ready_nxt;

  always_comb begin
    count_nxt = count_r;
    not_ready_nxt = not_ready_r;
    if (not_ready_r) begin
      if (count_r >= 32'(INIT_CYCLES - 1)) begin
        not_ready_nxt = 1'b0;
      end else begin
        count_nxt = count_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 32'h0000_0000;
      not_ready_r <= 1'b1;
    end else begin
      count_r <= count_nxt;
      not_ready_r <= not_ready_nxt;
    end
  end

  assign not_ready = not_ready_r;

  // Once ready the flag never returns without a reset
  chk_ready_stays: assert property (
    @(posedge clock) disable iff (!rst_n)
    !not_ready_r |=> !not_ready_r)
    else $error("not ready set again after init");
endmodule

// *** core/tsf_regs.sv ***
// Filter select, one-shot, common status and diode fault register bank
// Functional notes
// - Bits 3:2 choose remote 2 filter mode
// - Bits 1:0 choose remote 1 filter mode
// - Reserved bits of these registers read zero
// - One-shot write in standby starts one pass if not busy
// - One-shot data ignored, never stored
// - Common status bit 7 shows busy
// - Common status bit 6 set during init
// - Bits 3:0 OR status registers 4..1
// - Diode fault bits 3,2 remote 2 open/short
// - Diode fault bits 1,0 remote 1 open/short
// - Ground/D- is short; supply/floating is open
// - Faulted channel reads zero or minus 128
// - Config bit 6 selects standby
// - Threshold flags set at limit, hysteresis clear
`timescale 1ns/1ns
module tsf_regs
  import tsf_pkg::*;
#(
  parameter int INIT_CYCLES = TSF_INIT_CYCLES
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register access from the bus controller
  input tsf_reg_req_t req,
  output logic [7:0] rdata,
  // Conversion sequencer
  input wire logic conv_busy,
  input wire logic conv_done,
  output logic one_shot_start,
  output logic standby_select,
  output logic [2:0] chan_enable,
  // Threshold status registers 2..4 from the comparator logic
  input wire logic [2:0] thresh1_status,
  input wire logic [2:0] thresh2_status,
  input wire logic [2:0] thresh3_status,
  // Diode comparator levels
  input tsf_diode_sense_t remote1_sense,
  input tsf_diode_sense_t remote2_sense,
  // Filter control
  output tsf_filter_mode_t remote1_filter_mode,
  output tsf_filter_mode_t remote2_filter_mode,
  // Fault forcing of the value registers
  output logic remote1_force_fault,
  output logic remote2_force_fault,
  output logic [10:0] fault_unsigned_value,
  output logic [10:0] fault_signed_value
);
  logic [7:0] filter_r, filter_nxt;
  logic [7:0] config_r, config_nxt;
  logic [7:0] chan_en_r, chan_en_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic shot_r, shot_nxt;
  logic busy_r, busy_nxt;
  logic not_ready;
  tsf_fault_t r1_fault, r2_fault;
  logic [7:0] diode_status;
  logic [7:0] common_status;
  logic [1:0] remote1_filter_select;
  logic [1:0] remote2_filter_select;
  tsf_filter_mode_t r1_mode_r, r1_mode_nxt;
  tsf_filter_mode_t r2_mode_r, r2_mode_nxt;
  tsf_diode_sense_t chan_sense [2];
  tsf_fault_t chan_fault [2];

  // Index 0 is remote 1, index 1 is remote 2
  assign chan_sense[0] = remote1_sense;
  assign chan_sense[1] = remote2_sense;

  for (genvar ch = 0; ch < 2; ch++) begin : g_fault
    tsf_fault_class u_fault (
      .clock(clock),
      .rst_n(rst_n),
      .sense(chan_sense[ch]),
      .fault(chan_fault[ch])
    );
  end

  assign r1_fault = chan_fault[0];
  assign r2_fault = chan_fault[1];

  tsf_init_timer #(
    .INIT_CYCLES(INIT_CYCLES)
  ) u_init (
    .clock(clock),
    .rst_n(rst_n),
    .not_ready(not_ready)
  );

  assign remote2_filter_select = filter_r[TSF_REMOTE2_FILT_LSB +: 2];
  assign remote1_filter_select = filter_r[TSF_REMOTE1_FILT_LSB +: 2];

  // Reserved code 10 is not expected; treated as off to stay safe
  function automatic tsf_filter_mode_t decode_filter(input logic [1:0] sel);
    tsf_filter_mode_t m;
    case (sel)
      TSF_FILT_BASIC: m = TSF_FILTER_BASIC;
      TSF_FILT_ENH: m = TSF_FILTER_ENHANCED;
      default: m = TSF_FILTER_NONE;
    endcase
    return m;
  endfunction

  assign remote2_filter_mode = r2_mode_r;
  assign remote1_filter_mode = r1_mode_r;

  always_comb begin
    diode_status = 8'h00;
    diode_status[TSF_R2_OPEN_BIT] = r2_fault.open_fault;
    diode_status[TSF_R2_SHORT_BIT] = r2_fault.short_fault;
    diode_status[TSF_R1_OPEN_BIT] = r1_fault.open_fault;
    diode_status[TSF_R1_SHORT_BIT] = r1_fault.short_fault;
  end

  always_comb begin
    common_status = 8'h00;
    common_status[TSF_BUSY_BIT] = busy_r;
    common_status[TSF_NOT_READY_BIT] = not_ready;
    // Threshold flags arrive already hysteresis-qualified
    common_status[3] = |thresh3_status;
    common_status[2] = |thresh2_status;
    common_status[1] = |thresh1_status;
    common_status[0] = |diode_status;
  end

  // Busy set the cycle after a start, cleared on conv_done, else sequencer busy or held in standby
  always_comb begin
    filter_nxt = filter_r;
    config_nxt = config_r;
    chan_en_nxt = chan_en_r;
    shot_nxt = 1'b0;
    busy_nxt = busy_r;
    rdata_nxt = rdata_r;
    if (req.wr) begin
      case (req.cmd)
        TSF_CMD_FILTER: filter_nxt = req.wdata & TSF_FILTER_MASK;
        TSF_CMD_CONFIG: config_nxt = req.wdata & TSF_CONFIG_MASK;
        TSF_CMD_CHAN_ENABLE: chan_en_nxt = req.wdata & TSF_CHAN_EN_MASK;
        TSF_CMD_ONE_SHOT: begin
          // Data byte dropped; only the event matters
          // A start already in flight refuses a second one
          shot_nxt = config_r[TSF_STANDBY_BIT] && !busy_r
            && !shot_r;
        end
        default: begin
          // Read-only and unmapped commands hold state
        end
      endcase
    end
    // Decoded from the next value so modes and register move together
    r2_mode_nxt = decode_filter(filter_nxt[TSF_REMOTE2_FILT_LSB +: 2]);
    r1_mode_nxt = decode_filter(filter_nxt[TSF_REMOTE1_FILT_LSB +: 2]);
    if (shot_r) begin
      busy_nxt = 1'b1;
    end else if (conv_done) begin
      busy_nxt = 1'b0;
    end else begin
      busy_nxt = conv_busy || (busy_r && config_r[TSF_STANDBY_BIT]);
    end
    if (req.rd) begin
      case (req.cmd)
        TSF_CMD_COMMON_STATUS: rdata_nxt = common_status;
        TSF_CMD_CONFIG: rdata_nxt = config_r;
        TSF_CMD_CHAN_ENABLE: rdata_nxt = chan_en_r;
        TSF_CMD_FILTER: rdata_nxt = filter_r;
        TSF_CMD_DIODE_FAULT: rdata_nxt = diode_status;
        TSF_CMD_THRESH1: rdata_nxt = {5'h00, thresh1_status};
        TSF_CMD_THRESH2: rdata_nxt = {5'h00, thresh2_status};
        TSF_CMD_THRESH3: rdata_nxt = {5'h00, thresh3_status};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filter_r <= TSF_FILTER_RST;
      config_r <= TSF_CONFIG_RST;
      chan_en_r <= TSF_CHAN_EN_RST;
      shot_r <= 1'b0;
      busy_r <= 1'b0;
      rdata_r <= 8'h00;
      // Matches the filter reset value of enhanced on both channels
      r2_mode_r <= TSF_FILTER_ENHANCED;
      r1_mode_r <= TSF_FILTER_ENHANCED;
    end else begin
      filter_r <= filter_nxt;
      config_r <= config_nxt;
      chan_en_r <= chan_en_nxt;
      shot_r <= shot_nxt;
      busy_r <= busy_nxt;
      rdata_r <= rdata_nxt;
      r2_mode_r <= r2_mode_nxt;
      r1_mode_r <= r1_mode_nxt;
    end
  end

  assign rdata = rdata_r;
  assign one_shot_start = shot_r;
  assign standby_select = config_r[TSF_STANDBY_BIT];
  assign chan_enable = chan_en_r[2:0];
  assign remote1_force_fault = r1_fault.open_fault | r1_fault.short_fault;
  assign remote2_force_fault = r2_fault.open_fault | r2_fault.short_fault;
  assign fault_unsigned_value = TSF_UNSIGNED_FAULT;
  assign fault_signed_value = TSF_SIGNED_FAULT;

  chk_filter_reserved: assert property (
    @(posedge clock) disable iff (!rst_n)
    (filter_r & ~TSF_FILTER_MASK) == 8'h00)
    else $error("filter reserved bits set");

  chk_oneshot_standby: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.wr && req.cmd == TSF_CMD_ONE_SHOT && config_r[TSF_STANDBY_BIT]
    && !busy_r && !shot_r |=> shot_r ##1 busy_r)
    else $error("one-shot in standby did not start");

  chk_oneshot_active: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.wr && req.cmd == TSF_CMD_ONE_SHOT && !config_r[TSF_STANDBY_BIT]
    |=> !shot_r)
    else $error("one-shot honoured outside standby");

  chk_oneshot_nostore: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.wr && req.cmd == TSF_CMD_ONE_SHOT |=> $stable(filter_r)
    && $stable(config_r) && $stable(chan_en_r))
    else $error("one-shot data stored");

  chk_busy_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.rd && req.cmd == TSF_CMD_COMMON_STATUS
    |=> rdata[TSF_BUSY_BIT] == $past(busy_r))
    else $error("busy bit mismatch");

  chk_not_ready_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.rd && req.cmd == TSF_CMD_COMMON_STATUS
    |=> rdata[TSF_NOT_READY_BIT] == $past(not_ready))
    else $error("not ready bit mismatch");

  chk_summary_or: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.rd && req.cmd == TSF_CMD_COMMON_STATUS
    |=> rdata[3:0] == {|$past(thresh3_status), |$past(thresh2_status),
    |$past(thresh1_status), |$past(diode_status)})
    else $error("summary flags mismatch");

  chk_r2_filter: assert property (
    @(posedge clock) disable iff (!rst_n)
    remote2_filter_select == TSF_FILT_ENH
    |-> remote2_filter_mode == TSF_FILTER_ENHANCED)
    else $error("remote 2 filter mode wrong");

  chk_r2_filter_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    remote2_filter_select == TSF_FILT_OFF
    |-> remote2_filter_mode == TSF_FILTER_NONE)
    else $error("remote 2 filter not off");

  chk_r1_filter: assert property (
    @(posedge clock) disable iff (!rst_n)
    remote1_filter_select == TSF_FILT_BASIC
    |-> remote1_filter_mode == TSF_FILTER_BASIC)
    else $error("remote 1 filter mode wrong");

  // A config write in the same cycle may legally change standby
  chk_done_clears: assert property (
    @(posedge clock) disable iff (!rst_n)
    conv_done && !shot_r && !(req.wr && req.cmd == TSF_CMD_CONFIG)
    |=> !busy_r && $stable(config_r))
    else $error("busy not cleared after pass");

  chk_shot_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    shot_r |=> !shot_r)
    else $error("one-shot start longer than a cycle");

  chk_shot_in_standby: assert property (
    @(posedge clock) disable iff (!rst_n)
    shot_r |-> standby_select && !$past(busy_r))
    else $error("one-shot start outside standby");

  chk_busy_after_shot: assert property (
    @(posedge clock) disable iff (!rst_n)
    shot_r |=> busy_r)
    else $error("busy not raised after start");

  chk_ro_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.wr && req.cmd == TSF_CMD_DIODE_FAULT |=> $stable(filter_r)
    && $stable(config_r))
    else $error("read-only write changed state");

  chk_status_ro_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.wr && req.cmd == TSF_CMD_COMMON_STATUS |=> $stable(filter_r)
    && $stable(config_r) && $stable(chan_en_r))
    else $error("status write changed state");

  chk_diode_reserved: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.rd && req.cmd == TSF_CMD_DIODE_FAULT |=> rdata[7:4] == 4'h0)
    else $error("diode fault reserved bits set");

  chk_common_reserved: assert property (
    @(posedge clock) disable iff (!rst_n)
    req.rd && req.cmd == TSF_CMD_COMMON_STATUS |=> rdata[5:4] == 2'h0)
    else $error("common status reserved bits set");

  chk_fault_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    diode_status[TSF_R1_SHORT_BIT] == r1_fault.short_fault
    && diode_status[TSF_R2_OPEN_BIT] == r2_fault.open_fault)
    else $error("diode fault bits mismatch");
endmodule

// *** tb/tsf_host_model.sv ***
// Host controller model issuing register accesses to the bank
`timescale 1ns/1ns
module tsf_host_model
  import tsf_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register access
  output tsf_reg_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;

  // One-cycle strobe, launched and dropped on falling edges
  task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clock);
    req.wr = 1'b1;
    req.cmd = cmd;
    req.wdata = data;
    @(negedge clock);
    req.wr = 1'b0;
    // Released lines show a new pattern so stale values cannot pass
    req.cmd = ~cmd;
    req.wdata = ~data;
  endtask

  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data);
    @(negedge clock);
    req.rd = 1'b1;
    req.cmd = cmd;
    @(negedge clock);
    req.rd = 1'b0;
    req.cmd = ~cmd;
    data = rdata;
  endtask

  // Only legal filter codes are ever sent
  task automatic write_filter(input logic [1:0] r2, input logic [1:0] r1);
    if (r2 != TSF_FILT_RSVD && r1 != TSF_FILT_RSVD) begin
      write_reg(TSF_CMD_FILTER, {4'hF, r2, r1});
    end
  endtask
endmodule

// *** tb/temp_sensor_filter_status_regs_test.sv ***
// Self-checking bench for the filter and status register bank
`timescale 1ns/1ns
module temp_sensor_filter_status_regs_test
  import tsf_pkg::*;
;
  localparam int INIT_N = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  tsf_reg_req_t req;
  logic [7:0] rdata, rv;
  logic conv_busy = 1'b0;
  logic conv_done = 1'b0;
  logic one_shot_start, standby_select, f1, f2;
  logic [2:0] chan_enable;
  logic [2:0] th1 = 3'h0;
  logic [2:0] th2 = 3'h0;
  logic [2:0] th3 = 3'h0;
  tsf_diode_sense_t s1 = '0;
  tsf_diode_sense_t s2 = '0;
  tsf_filter_mode_t m1, m2;
  logic [10:0] fu, fs;
  int err_total = 0;
  int n_compared = 0;
  int n_starts = 0;
  int seq_left = 0;

  always #5 clock = ~clock;

  tsf_host_model host (.clock(clock), .req(req), .rdata(rdata));

  tsf_regs #(.INIT_CYCLES(INIT_N)) DUT (
    .clock(clock), .rst_n(rst_n), .req(req), .rdata(rdata),
    .conv_busy(conv_busy), .conv_done(conv_done),
    .one_shot_start(one_shot_start), .standby_select(standby_select),
    .chan_enable(chan_enable), .thresh1_status(th1),
    .thresh2_status(th2), .thresh3_status(th3),
    .remote1_sense(s1), .remote2_sense(s2),
    .remote1_filter_mode(m1), .remote2_filter_mode(m2),
    .remote1_force_fault(f1), .remote2_force_fault(f2),
    .fault_unsigned_value(fu), .fault_signed_value(fs)
  );

  // Sequencer stand-in: a pass lasts five cycles after each start
  always @(negedge clock) begin
    conv_done <= 1'b0;
    if (seq_left != 0) begin
      seq_left <= seq_left - 1;
      conv_busy <= (seq_left != 1);
      conv_done <= (seq_left == 1);
    end
    if (one_shot_start === 1'b1) begin
      n_starts <= n_starts + 1;
      seq_left <= 5;
      conv_busy <= 1'b1;
    end
  end

  task automatic check(string what, logic [10:0] seen, logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wait_cycles(int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic test_reset_state();
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("not ready", rv, 8'h40);
    check("r1 mode", m1, TSF_FILTER_ENHANCED);
    check("r2 mode", m2, TSF_FILTER_ENHANCED);
    check("chan enable", chan_enable, 3'h7);
    host.read_reg(TSF_CMD_FILTER, rv);
    check("filter reset", rv, 8'h0F);
    wait_cycles(INIT_N);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("ready", rv, 8'h00);
  endtask

  task automatic test_filter();
    logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
    tsf_filter_mode_t modes [3] = '{TSF_FILTER_NONE, TSF_FILTER_BASIC,
      TSF_FILTER_ENHANCED};
    for (int i = 0; i < 3; i++) begin
      host.write_filter(codes[i], codes[2 - i]);
      check("r2 mode", m2, modes[i]);
      check("r1 mode", m1, modes[2 - i]);
      host.read_reg(TSF_CMD_FILTER, rv);
      check("filter read", rv, {4'h0, codes[i], codes[2 - i]});
    end
  endtask

  task automatic test_one_shot();
    int n0;
    n0 = n_starts;
    host.write_reg(TSF_CMD_ONE_SHOT, 8'hFF);
    wait_cycles(4);
    check("active start", n_starts, n0);
    host.write_reg(TSF_CMD_CONFIG, 8'h40);
    check("standby", standby_select, 1'b1);
    host.write_reg(TSF_CMD_ONE_SHOT, 8'hA5);
    for (int i = 0; i < 10 && n_starts == n0; i++) begin
      @(negedge clock);
    end
    check("standby start", n_starts, n0 + 1);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("busy", rv, 8'h80);
    wait_cycles(8);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("idle", rv, 8'h00);
    check("still standby", standby_select, 1'b1);
    host.read_reg(TSF_CMD_ONE_SHOT, rv);
    check("not stored", rv, 8'h00);
  endtask

  task automatic test_summary();
    th1 = 3'h4;
    th3 = 3'h1;
    wait_cycles(2);
    host.write_reg(TSF_CMD_COMMON_STATUS, 8'hFF);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("summary", rv, 8'h0A);
    th1 = 3'h0;
    th2 = 3'h2;
    th3 = 3'h0;
    wait_cycles(2);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("summary 2", rv, 8'h04);
    th2 = 3'h0;
  endtask

  task automatic test_faults();
    s1.dplus_low = 1'b1;
    s2.dplus_high = 1'b1;
    wait_cycles(8);
    host.write_reg(TSF_CMD_DIODE_FAULT, 8'hF0);
    host.read_reg(TSF_CMD_DIODE_FAULT, rv);
    check("faults", rv, 8'h09);
    host.read_reg(TSF_CMD_COMMON_STATUS, rv);
    check("fault summary", rv, 8'h01);
    check("forced", {f2, f1}, 2'h3);
    check("unsigned", fu, 11'h000);
    check("signed", fs, 11'h400);
    s1 = '{dplus_low: 1'b0, dplus_high: 1'b1};
    s2 = '{dplus_low: 1'b1, dplus_high: 1'b0};
    wait_cycles(8);
    host.read_reg(TSF_CMD_DIODE_FAULT, rv);
    check("faults swap", rv, 8'h06);
    s1 = '0;
    s2 = '0;
    wait_cycles(8);
    check("released", {f2, f1}, 2'h0);
  endtask

  // Guard against a hung run
  initial begin
    #100000;
    err_total++;
    close_out();
  end

  initial begin
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    test_reset_state();
    test_filter();
    test_one_shot();
    test_summary();
    test_faults();
    close_out();
  end
endmodule
